// ==== design/dtc_params.svh ====
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ============================================================
// register word offsets (byte address divided by four)
`define DTC_OFS_CTRL      6'h00
`define DTC_OFS_MODE      6'h01
`define DTC_OFS_T0LO      6'h02
`define DTC_OFS_T0HI      6'h03
`define DTC_OFS_T1LO      6'h04
`define DTC_OFS_T1HI      6'h05
`define DTC_OFS_IEN       6'h06
`define DTC_OFS_DIV       6'h07
`define DTC_OFS_IRQ       6'h08

// ============================================================
// control register fields
`define DTC_TF1           7
`define DTC_TR1           6
`define DTC_TF0           5
`define DTC_TR0           4
`define DTC_CTRL_WMASK    8'hF0

// ============================================================
// mode register fields
`define DTC_CT1           6
`define DTC_M1_HI         5
`define DTC_M1_LO         4
`define DTC_T0_GATE_ENABLE         3
`define DTC_CT0           2
`define DTC_M0_HI         1
`define DTC_M0_LO         0
`define DTC_MODE_WMASK    8'h7F

// ============================================================
// interrupt enable fields
`define DTC_EA            7
`define DTC_T1_OVERFLOW_IRQ_ENABLE          3
`define DTC_T0IE          1
`define DTC_IEN_WMASK     8'h8A

// ============================================================
// vectors, prescaler, reset values
`define DTC_VEC_T0        8'h0B
`define DTC_VEC_T1        8'h1B
`define DTC_PRE_LAST      4'hB
`define DTC_RST_BYTE      8'h00
`define DTC_BYTE_ONES     8'hFF
`define DTC_M0_ONES       13'h1FFF
`define DTC_M1_ONES       16'hFFFF
`define DTC_LOW5_ZERO     3'h0

`endif

// ==== design/dtc_pkg.sv ====
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } dtc_ahb_in_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } dtc_ahb_out_t;

    typedef struct packed {
        logic ext_irq_zero_pin;
        logic t1_count_pin;
        logic t0_count_pin;
    } dtc_pins_t;

    typedef struct packed {
        logic       irq_req;
        logic [7:0] irq_vector;
    } dtc_irq_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic       ovf;
    } dtc_step_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  mode;
        logic [7:0]  ien;
        logic [7:0]  div;
        logic [7:0]  t0lo;
        logic [7:0]  t0hi;
        logic [7:0]  t1lo;
        logic [7:0]  t1hi;
        logic [7:0]  divcnt;
        logic [3:0]  pre;
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic [2:0]  s3;
        logic        wr_pend;
        logic [5:0]  waddr;
        logic [31:0] rdata;
        logic        irq;
        logic [7:0]  vec;
    } dtc_state_t;

endpackage : dtc_pkg

// ==== design/dtc_top.sv ====
// Chosen here: the AHB-Lite register port and the register addresses.
`include "dtc_params.svh"

module dtc_top (
    input  wire logic           clk,     // system clock
    input  wire logic           nrst,    // async reset, active low
    input  dtc_pkg::dtc_ahb_in_t  ahb_i, // ahb-lite slave inputs
    output dtc_pkg::dtc_ahb_out_t ahb_o, // ahb-lite slave outputs
    input  dtc_pkg::dtc_pins_t    pins_i,// count and gate pins
    input  wire logic           irq_ack, // service pulse from cpu
    output dtc_pkg::dtc_irq_t     irq_o  // request and vector
);
    import dtc_pkg::*;

    dtc_state_t s;
    dtc_state_t n;

    // ============================================================
    // one timer step for modes 0..2, and split low byte
    function automatic dtc_step_t tmr_step(
        input dtc_mode_t  md,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        dtc_step_t  r;
        logic [12:0] c13;
        logic [15:0] c16;
        r   = '{lo: lo, hi: hi, ovf: 1'b0};
        c13 = {hi, lo[4:0]};
        c16 = {hi, lo};
        unique case (md)
            DTC_MODE_13BIT: begin
                r.ovf = (c13 == `DTC_M0_ONES);
                c13   = c13 + 13'h0001;
                r.lo  = {`DTC_LOW5_ZERO, c13[4:0]};
                r.hi  = c13[12:5];
            end
            DTC_MODE_16BIT: begin
                r.ovf = (c16 == `DTC_M1_ONES);
                c16   = c16 + 16'h0001;
                r.lo  = c16[7:0];
                r.hi  = c16[15:8];
            end
            DTC_MODE_RELOAD: begin
                r.ovf = (lo == `DTC_BYTE_ONES);
                r.lo  = r.ovf ? hi : lo + 8'h01;
            end
            DTC_MODE_SPLIT: begin
                r.ovf = (lo == `DTC_BYTE_ONES);
                r.lo  = lo + 8'h01;
            end
        endcase
        return r;
    endfunction : tmr_step

    // ============================================================
    // rate generation
    logic      sys_en;
    logic      tick12;
    logic [2:0] fall;
    dtc_mode_t md0;
    dtc_mode_t md1;
    logic      t1_gate;
    logic      run0;
    logic      run1;
    logic      src0;
    logic      src1;
    logic      step0;
    logic      step1;
    logic      steph;
    logic      addr_ok;
    logic      wr_now;
    dtc_step_t r0;
    dtc_step_t r1;
    logic      set0;
    logic      set1;
    logic      pend0;
    logic      pend1;

    // a lowered divider must not leave the count stranded above it
    assign sys_en  = (s.divcnt >= s.div);
    assign tick12  = sys_en && (s.pre == `DTC_PRE_LAST);
    assign fall    = s.s3 & ~s.s2;
    assign md0     = dtc_mode_t'(s.mode[`DTC_M0_HI:`DTC_M0_LO]);
    assign md1     = dtc_mode_t'(s.mode[`DTC_M1_HI:`DTC_M1_LO]);
    assign t1_gate = 1'b1;

    // ============================================================
    // count enables
    assign run0  = s.ctrl[`DTC_TR0] &&
                   (!s.mode[`DTC_T0_GATE_ENABLE] || s.s2[2]);
    assign run1  = s.ctrl[`DTC_TR1] && t1_gate;
    assign src0  = s.mode[`DTC_CT0] ? fall[0] : tick12;
    assign src1  = s.mode[`DTC_CT1] ? fall[1] : tick12;
    assign step0 = run0 && src0;
    assign step1 = run1 && src1 && (md1 != DTC_MODE_SPLIT);
    assign steph = (md0 == DTC_MODE_SPLIT) &&
                   s.ctrl[`DTC_TR1] && tick12;
    assign r0    = tmr_step(md0, s.t0lo, s.t0hi);
    assign r1    = tmr_step(md1, s.t1lo, s.t1hi);
    assign set0  = step0 && r0.ovf;
    assign set1  = (steph && (s.t0hi == `DTC_BYTE_ONES)) ||
                   (step1 && r1.ovf && (md0 != DTC_MODE_SPLIT));

    // ============================================================
    // bus decode
    assign addr_ok = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
    assign wr_now  = s.wr_pend;

    // ============================================================
    // next state
    always_comb begin
        n = s;
        // pin synchronisers and falling edge history
        n.s1 = {pins_i.ext_irq_zero_pin, pins_i.t1_count_pin,
                pins_i.t0_count_pin};
        n.s2 = s.s1;
        n.s3 = s.s2;
        // divider then twelve-cycle prescaler
        n.divcnt = sys_en ? `DTC_RST_BYTE : s.divcnt + 8'h01;
        if (sys_en) begin
            n.pre = (s.pre == `DTC_PRE_LAST) ? 4'h0 : s.pre + 4'h1;
        end
        // timer zero
        if (step0) begin
            n.t0lo = r0.lo;
            if (md0 != DTC_MODE_SPLIT) begin
                n.t0hi = r0.hi;
            end
        end
        if (steph) begin
            n.t0hi = s.t0hi + 8'h01;
        end
        // timer one
        if (step1) begin
            n.t1lo = r1.lo;
            n.t1hi = r1.hi;
        end
        // service clears the flag whose vector is shown
        if (irq_ack && s.irq) begin
            if (s.vec == `DTC_VEC_T0) begin
                n.ctrl[`DTC_TF0] = 1'b0;
            end else begin
                n.ctrl[`DTC_TF1] = 1'b0;
            end
        end
        // address phase
        n.wr_pend = addr_ok && ahb_i.hwrite;
        if (addr_ok && ahb_i.hwrite) begin
            n.waddr = ahb_i.haddr[7:2];
        end
        if (addr_ok && !ahb_i.hwrite) begin
            unique case (ahb_i.haddr[7:2])
                `DTC_OFS_CTRL: n.rdata = {24'h0, s.ctrl};
                `DTC_OFS_MODE: n.rdata = {24'h0, s.mode};
                `DTC_OFS_T0LO: n.rdata = {24'h0, s.t0lo};
                `DTC_OFS_T0HI: n.rdata = {24'h0, s.t0hi};
                `DTC_OFS_T1LO: n.rdata = {24'h0, s.t1lo};
                `DTC_OFS_T1HI: n.rdata = {24'h0, s.t1hi};
                `DTC_OFS_IEN:  n.rdata = {24'h0, s.ien};
                `DTC_OFS_DIV:  n.rdata = {24'h0, s.div};
                `DTC_OFS_IRQ:  n.rdata = {23'h0, s.irq, s.vec};
                default:       n.rdata = 32'h0;
            endcase
        end
        // data phase write, overrides a same-cycle count step
        if (wr_now) begin
            unique case (s.waddr)
                `DTC_OFS_CTRL: n.ctrl = ahb_i.hwdata[7:0] &
                                        `DTC_CTRL_WMASK;
                `DTC_OFS_MODE: n.mode = ahb_i.hwdata[7:0] &
                                        `DTC_MODE_WMASK;
                `DTC_OFS_T0LO: n.t0lo = ahb_i.hwdata[7:0];
                `DTC_OFS_T0HI: n.t0hi = ahb_i.hwdata[7:0];
                `DTC_OFS_T1LO: n.t1lo = ahb_i.hwdata[7:0];
                `DTC_OFS_T1HI: n.t1hi = ahb_i.hwdata[7:0];
                `DTC_OFS_IEN:  n.ien  = ahb_i.hwdata[7:0] &
                                        `DTC_IEN_WMASK;
                `DTC_OFS_DIV:  n.div  = ahb_i.hwdata[7:0];
                default: ;
            endcase
        end
        // hardware set wins over any clear
        if (set0) begin
            n.ctrl[`DTC_TF0] = 1'b1;
        end
        if (set1) begin
            n.ctrl[`DTC_TF1] = 1'b1;
        end
        // request and vector follow the new flags
        pend0 = n.ien[`DTC_EA] && n.ien[`DTC_T0IE] &&
                n.ctrl[`DTC_TF0];
        pend1 = n.ien[`DTC_EA] && n.ien[`DTC_T1_OVERFLOW_IRQ_ENABLE] &&
                n.ctrl[`DTC_TF1];
        n.irq = pend0 || pend1;
        n.vec = pend0 ? `DTC_VEC_T0 : `DTC_VEC_T1;
    end

    // ============================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ============================================================
    // outputs
    assign ahb_o.hrdata     = s.rdata;
    assign ahb_o.hreadyout  = 1'b1;
    assign ahb_o.hresp      = 1'b0;
    assign irq_o.irq_req    = s.irq;
    assign irq_o.irq_vector = s.vec;

    // ============================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence seq_reload_wrap;
        (md0 == DTC_MODE_RELOAD) && step0 &&
        (s.t0lo == `DTC_BYTE_ONES) && !wr_now;
    endsequence

    sequence seq_m0_wrap;
        (md0 == DTC_MODE_13BIT) && step0 &&
        ({s.t0hi, s.t0lo[4:0]} == `DTC_M0_ONES) && !wr_now;
    endsequence

    sequence seq_gate_closed;
        s.ctrl[`DTC_TR0] && s.mode[`DTC_T0_GATE_ENABLE] && !s.s2[2] &&
        (md0 != DTC_MODE_SPLIT) && !wr_now;
    endsequence

    a_prescale_gap: assert property (
        tick12 |=> !tick12 [*8]
    ) else $error("prescaled tick came too early");

    a_divider_slows: assert property (
        sys_en && (s.div != `DTC_RST_BYTE) &&
        !(wr_now && (s.waddr == `DTC_OFS_DIV)) |=> !sys_en
    ) else $error("divider did not slow the timer clock");

    a_edge_counts: assert property (
        s.mode[`DTC_CT0] && s.ctrl[`DTC_TR0] && !s.mode[`DTC_T0_GATE_ENABLE] &&
        (md0 == DTC_MODE_16BIT) && fall[0] && !wr_now
        |=> ({s.t0hi, s.t0lo} == $past({s.t0hi, s.t0lo}) + 16'h0001)
    ) else $error("falling edge not counted");

    a_gate_stops: assert property (
        seq_gate_closed |=> $stable({s.t0hi, s.t0lo})
    ) else $error("timer zero counted with gate low");

    a_gate_ignored: assert property (
        !s.mode[`DTC_T0_GATE_ENABLE] && s.ctrl[`DTC_TR0] && src0
        |-> step0
    ) else $error("gate pin affected timer zero");

    a_run_off_holds: assert property (
        !s.ctrl[`DTC_TR0] && (md0 != DTC_MODE_SPLIT) && !wr_now
        |=> $stable({s.t0hi, s.t0lo})
    ) else $error("timer zero moved while stopped");

    a_mode0_flag: assert property (
        seq_m0_wrap |=> s.ctrl[`DTC_TF0] && (s.t0hi == `DTC_RST_BYTE)
    ) else $error("mode 0 wrap missed flag");

    a_reload_value: assert property (
        seq_reload_wrap |=> (s.t0lo == $past(s.t0hi)) &&
                            s.ctrl[`DTC_TF0]
    ) else $error("mode 2 reload wrong");

    a_t1_split_holds: assert property (
        (md1 == DTC_MODE_SPLIT) && !wr_now
        |=> $stable({s.t1hi, s.t1lo})
    ) else $error("timer one moved in mode 3");

    a_split_high: assert property (
        steph && (s.t0hi == `DTC_BYTE_ONES) |=> s.ctrl[`DTC_TF1]
    ) else $error("split high wrap missed timer one flag");

    a_priority_t0: assert property (
        s.irq && s.ctrl[`DTC_TF0] && s.ien[`DTC_T0IE]
        |-> (s.vec == `DTC_VEC_T0)
    ) else $error("timer zero lost priority");

    a_global_mask: assert property (
        !s.ien[`DTC_EA] |-> !s.irq
    ) else $error("request raised with global enable off");

    a_ack_clears: assert property (
        irq_ack && s.irq && (s.vec == `DTC_VEC_T0) && !set0 && !wr_now
        |=> !s.ctrl[`DTC_TF0]
    ) else $error("service did not clear timer zero flag");

endmodule : dtc_top

// ==== verif/dtc_event_src.sv ====
// ============================================================
// external count and gate sources
module dtc_event_src
    import dtc_pkg::*;
(
    input  wire logic          clk,   // system clock
    output dtc_pkg::dtc_pins_t pins_o // count and gate pins
);
    timeunit 1ns;
    timeprecision 100ps;

    dtc_pins_t pins_q = 3'h7;

    assign pins_o = pins_q;

    // each level held three clocks, above the one-clock minimum
    task automatic drive(input int which, input logic v);
        @(posedge clk);
        if (which == 0) begin
            pins_q.t0_count_pin <= v;
        end else begin
            pins_q.t1_count_pin <= v;
        end
        repeat (2) @(posedge clk);
    endtask : drive

    task automatic pulse(input int which, input int n);
        repeat (n) begin
            drive(which, 1'h0);
            drive(which, 1'h1);
        end
    endtask : pulse

    task automatic gate(input logic v);
        @(posedge clk);
        pins_q.ext_irq_zero_pin <= v;
    endtask : gate
endmodule : dtc_event_src

// ==== verif/dual_timer_counter_unit_tb.sv ====
`include "dtc_params.svh"

module dual_timer_counter_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dtc_pkg::*;

    typedef struct {
        int t, mr, lo, hi, k, d, g, en;
    } dtc_case_t;

    logic         clk     = 1'h0;
    logic         nrst    = 1'h0;
    logic         irq_ack = 1'h0;
    logic         sel     = 1'h0;
    logic [31:0]  addr    = 32'h0;
    logic [31:0]  wdata   = 32'h0;
    logic [1:0]   trans   = 2'h0;
    logic         wr      = 1'h0;
    logic [2:0]   size    = 3'h2;
    dtc_ahb_in_t  ahb_i;
    dtc_ahb_out_t ahb_o;
    dtc_pins_t    pins;
    dtc_irq_t     irq;
    int           fails   = 0;
    int           checked = 0;
    int           cyc     = 0;
    dtc_case_t    cases[8] = '{
        '{0, 'h00, 'h1F, 'hFF, 3, 0, 1, 1},
        '{0, 'h01, 'hFE, 'hFF, 3, 0, 1, 1},
        '{0, 'h02, 'hFE, 'h80, 3, 0, 1, 1},
        '{1, 'h10, 'h10, 'h00, 2, 1, 1, 1},
        '{1, 'h20, 'hFF, 'hC0, 2, 0, 0, 1},
        '{0, 'h09, 'h00, 'h00, 2, 0, 0, 0},
        '{0, 'h09, 'h00, 'h00, 2, 2, 1, 1},
        '{0, 'h01, 'h00, 'h00, 2, 0, 0, 1}};
    int           msk[10] = '{'hF0, 'h7F, 'hFF, 'hFF, 'hFF, 'hFF,
                              'h8A, 'hFF, 'h00, 'h00};
    int           irqv[3] = '{'h0A, 'h88, 'h8A};
    int           irqe[3] = '{'h01B, 'h11B, 'h10B};

    assign ahb_i = {sel, addr, trans, wr, size, wdata, ahb_o.hreadyout};

    always #5 clk = ~clk;

    dtc_top u_dut (
        .clk    (clk),
        .nrst   (nrst),
        .ahb_i  (ahb_i),
        .ahb_o  (ahb_o),
        .pins_i (pins),
        .irq_ack(irq_ack),
        .irq_o  (irq)
    );

    dtc_event_src u_src (
        .clk   (clk),
        .pins_o(pins)
    );

    // ============================================================
    // checking and closing
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    // ============================================================
    // bus master, single word transfers
    task automatic bus(input int o, input logic w, input int d,
                       output logic [31:0] rd);
        sel   <= 1'h1;
        addr  <= o * 4;
        trans <= 2'h2;
        wr    <= w;
        @(posedge clk);
        while (ahb_o.hreadyout !== 1'h1) @(posedge clk);
        sel   <= 1'h0;
        trans <= 2'h0;
        wdata <= d;
        @(posedge clk);
        while (ahb_o.hreadyout !== 1'h1) @(posedge clk);
        rd = ahb_o.hrdata;
    endtask : bus

    task automatic wr_reg(input int o, input int d);
        logic [31:0] x;
        bus(o, 1'h1, d, x);
    endtask : wr_reg

    task automatic rd_reg(input int o, output logic [31:0] r);
        bus(o, 1'h0, 0, r);
    endtask : rd_reg

    task automatic ack();
        irq_ack <= 1'h1;
        @(posedge clk);
        irq_ack <= 1'h0;
        repeat (2) @(posedge clk);
    endtask : ack

    // ============================================================
    // reference model: n count steps in a given mode
    function automatic logic [16:0] mdl(input int md, input int lo,
                                        input int hi, input int n);
        int   v;
        logic ov;
        ov = 1'h0;
        for (int i = 0; i < n; i++) begin
            if (md == 2) begin
                lo++;
                ov = ov | (lo == 256);
                lo = (lo == 256) ? hi : lo;
            end else begin
                v = (md == 0) ? hi * 32 + (lo & 31) + 1 : hi * 256 + lo + 1;
                ov = ov | (v == ((md == 0) ? 8192 : 65536));
                lo = (md == 0) ? v & 31 : v & 255;
                hi = (md == 0) ? (v >> 5) & 255 : (v >> 8) & 255;
            end
        end
        return {ov, hi[7:0], lo[7:0]};
    endfunction : mdl

    // window of exactly k base ticks; flags read before stopping
    task automatic run_case(input dtc_case_t c);
        logic [31:0] f;
        logic [31:0] r;
        logic [16:0] e;
        int          md;
        int          ol;
        md = c.t ? (c.mr >> 4) & 3 : c.mr & 3;
        ol = `DTC_OFS_T0LO + 2 * c.t;
        u_src.gate(c.g[0]);
        wr_reg(`DTC_OFS_DIV, c.d);
        wr_reg(`DTC_OFS_MODE, c.mr);
        wr_reg(ol, c.lo);
        wr_reg(ol + 1, c.hi);
        wr_reg(`DTC_OFS_CTRL, c.t ? 'h40 : 'h10);
        repeat (12 * (c.d + 1) * c.k - 3) @(posedge clk);
        rd_reg(`DTC_OFS_CTRL, f);
        wr_reg(`DTC_OFS_CTRL, 0);
        e = mdl(md, c.lo, c.hi, c.en ? c.k : 0);
        rd_reg(ol, r);
        chk("low byte", (md == 0) ? r & 'h1F : r, e[7:0]);
        rd_reg(ol + 1, r);
        chk("high byte", r, e[15:8]);
        chk("overflow flag", f[c.t ? 7 : 5], e[16]);
    endtask : run_case

    // ============================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic [31:0] v;
        void'($urandom(32'h062B67A5));
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        for (int o = 0; o < 10; o++) begin
            rd_reg(o, r);
            chk("reset value", r, (o == 8) ? 'h1B : 0);
        end
        chk("bus response", ahb_o.hresp, 0);
        for (int o = 0; o < 10; o++) begin
            v = $urandom;
            wr_reg(o, v);
            rd_reg(o, r);
            chk("access mask", r, (v & msk[o]) | ((o == 8) ? 'h1B : 0));
            wr_reg(o, 0);
        end
        foreach (cases[i]) begin
            run_case(cases[i]);
        end
        wr_reg(`DTC_OFS_MODE, 'h55);
        for (int o = 2; o < 6; o++) begin
            wr_reg(o, 0);
        end
        wr_reg(`DTC_OFS_CTRL, 'h50);
        u_src.pulse(0, 5);
        u_src.pulse(1, 3);
        repeat (4) @(posedge clk);
        wr_reg(`DTC_OFS_CTRL, 0);
        u_src.pulse(0, 2);
        repeat (4) @(posedge clk);
        rd_reg(`DTC_OFS_T0LO, r);
        chk("t0 events", r, mdl(1, 0, 0, 5) & 'hFF);
        rd_reg(`DTC_OFS_T1LO, r);
        chk("t1 events", r, mdl(1, 0, 0, 3) & 'hFF);
        wr_reg(`DTC_OFS_DIV, 0);
        wr_reg(`DTC_OFS_MODE, 'h33);
        wr_reg(`DTC_OFS_T0LO, 'h10);
        wr_reg(`DTC_OFS_T0HI, 'hFF);
        wr_reg(`DTC_OFS_T1LO, 'h55);
        wr_reg(`DTC_OFS_T1HI, 'h66);
        wr_reg(`DTC_OFS_CTRL, 'h50);
        repeat (21) @(posedge clk);
        rd_reg(`DTC_OFS_CTRL, v);
        wr_reg(`DTC_OFS_CTRL, v & 'hA0);
        chk("split flags", v & 'hA0, 'h80);
        for (int o = 2; o < 6; o++) begin
            rd_reg(o, r);
            chk("split bytes", r, (o < 4) ? 16'h1201 >> (24 - 8 * o) & 'hFF
                                          : 'h11 * o + 'h11);
        end
        wr_reg(`DTC_OFS_CTRL, 'hA0);
        foreach (irqv[i]) begin
            wr_reg(`DTC_OFS_IEN, irqv[i]);
            repeat (2) @(posedge clk);
            rd_reg(`DTC_OFS_IRQ, r);
            chk("irq status", r, irqe[i]);
            chk("irq port", irq, irqe[i]);
        end
        ack();
        chk("irq after ack", irq, {1'h1, `DTC_VEC_T1});
        rd_reg(`DTC_OFS_CTRL, r);
        chk("flags after ack", r, 'h80);
        ack();
        chk("irq idle", irq, {1'h0, `DTC_VEC_T1});
        wr_reg(`DTC_OFS_CTRL, 'hA0);
        wr_reg(`DTC_OFS_CTRL, 'h00);
        repeat (2) @(posedge clk);
        chk("sw clear", irq, {1'h0, `DTC_VEC_T1});
        end_sim();
    end
endmodule : dual_timer_counter_unit_tb
